// ===== rtl/rffe_host.sv
// Host controller: register commands sent over the serial link
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module rffe_host
  import rffe_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  rffe_link_if.host        LINK,
  input  wire logic [2:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA
);
  rffe_hstate_t state_ff;
  logic [15:0] frame_ff;
  logic [7:0]  rx_ff;
  logic [4:0]  bit_ff;
  logic [7:0]  div_ff;
  logic        sck_ff;
  logic        cs_n_ff;
  logic        rst_n_ff;
  logic        wake_ff;
  logic        done_ff;
  logic [15:0] rdata_ff;
  logic        sdo_s1_ff;
  logic        sdo_s2_ff;
  logic        int_s1_ff;
  logic        int_s2_ff;
  logic        tick;

  assign tick = (div_ff == 8'(SCK_HALF_DIV - 1));

  always_ff @(posedge CORE_CLK)
  begin
    sdo_s1_ff <= LINK.sdo_o;
    sdo_s2_ff <= sdo_s1_ff;
    int_s1_ff <= LINK.intr;
    int_s2_ff <= int_s1_ff;
  end

  // Divider makes the link clock; only runs inside a frame
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || state_ff != RFFE_SHIFT)
      div_ff <= 8'h00;
    else if (tick)
      div_ff <= 8'h00;
    else
      div_ff <= div_ff + 8'h01;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_ff <= RFFE_IDLE;
      frame_ff <= 16'h0000;
      rx_ff    <= 8'h00;
      bit_ff   <= 5'h00;
      sck_ff   <= 1'b0;
      cs_n_ff  <= 1'b1;
      done_ff  <= 1'b0;
    end
    else
    begin
      case (state_ff)
        RFFE_IDLE:
        begin
          if (WR && ADDR == 3'(HOST_CTRL_ADDR))
          begin
            // Software orders mode, direction, level writes in turn
            frame_ff <= WDATA;
            bit_ff   <= 5'h00;
            cs_n_ff  <= 1'b0;
            done_ff  <= 1'b0;
            state_ff <= RFFE_SHIFT;
          end
        end
        RFFE_SHIFT:
        begin
          if (tick)
          begin
            sck_ff <= ~sck_ff;
            if (sck_ff)
            begin
              frame_ff <= {frame_ff[14:0], 1'b0};
              rx_ff    <= {rx_ff[6:0], sdo_s2_ff};
              bit_ff   <= bit_ff + 5'h01;
              if (bit_ff == 5'(FRAME_BITS - 1))
                state_ff <= RFFE_DONE;
            end
          end
        end
        RFFE_DONE:
        begin
          cs_n_ff  <= 1'b1;
          done_ff  <= 1'b1;
          state_ff <= RFFE_IDLE;
        end
        default:
          state_ff <= RFFE_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      rst_n_ff <= 1'b0;
      wake_ff  <= 1'b0;
    end
    else if (WR && ADDR == 3'(HOST_PINS_ADDR))
    begin
      rst_n_ff <= WDATA[0];
      wake_ff  <= WDATA[1];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      rdata_ff <= 16'h0000;
    else if (RD)
    begin
      if (ADDR == 3'(HOST_STAT_ADDR))
        rdata_ff <= {13'h0000, int_s2_ff, done_ff,
                     state_ff != RFFE_IDLE};
      else if (ADDR == 3'(HOST_RDATA_ADDR))
        rdata_ff <= {8'h00, rx_ff};
      else if (ADDR == 3'(HOST_PINS_ADDR))
        rdata_ff <= {14'h0000, wake_ff, rst_n_ff};
      else
        rdata_ff <= 16'h0000;
    end
  end

  assign RDATA        = rdata_ff;
  assign LINK.sck     = sck_ff;
  assign LINK.sdi     = frame_ff[15];
  assign LINK.cs_n    = cs_n_ff;
  assign LINK.reset_n = rst_n_ff;
  assign LINK.wake    = wake_ff;
endmodule : rffe_host

// ===== shared/rffe_pkg.sv
// Shared constants and types for the front-end switch control link
package rffe_pkg;
  localparam int unsigned ADDR_W          = 6;
  localparam int unsigned DATA_W          = 8;
  localparam logic [5:0]  REG_TEST_MODE   = 6'h22;
  localparam logic [5:0]  REG_LEVEL_ALT   = 6'h32;
  localparam logic [5:0]  REG_LEVEL       = 6'h33;
  localparam logic [5:0]  REG_DIRECTION   = 6'h34;
  localparam logic [5:0]  REG_STATUS      = 6'h35;
  localparam int unsigned BIT_AMP_EN      = 1;
  localparam int unsigned BIT_LNA_EN      = 2;
  localparam int unsigned BIT_SUPPLY_EN   = 3;
  localparam logic [2:0]  MODE_NORMAL     = 3'h0;
  localparam logic [2:0]  MODE_FRONT_END  = 3'h7;
  localparam logic [7:0]  RST_REG         = 8'h00;
  localparam int unsigned SCK_HALF_DIV    = 4;
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned HOST_CTRL_ADDR  = 0;
  localparam int unsigned HOST_WDATA_ADDR = 1;
  localparam int unsigned HOST_STAT_ADDR  = 2;
  localparam int unsigned HOST_RDATA_ADDR = 3;
  localparam int unsigned HOST_PINS_ADDR  = 4;

  typedef enum logic [1:0]
  {
    RFFE_IDLE  = 2'b00,
    RFFE_SHIFT = 2'b01,
    RFFE_DONE  = 2'b10
  } rffe_hstate_t;
endpackage : rffe_pkg

// ===== shared/rffe_link_if.sv
// Pin-level link between host controller and radio front-end device
`timescale 1ns/100ps
interface rffe_link_if;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic cs_n;
  logic reset_n;
  logic wake;
  logic intr;

  modport device
  (
    input  sck,
    input  sdi,
    output sdo_o,
    output sdo_oe,
    input  cs_n,
    input  reset_n,
    input  wake,
    output intr
  );

  modport host
  (
    output sck,
    output sdi,
    input  sdo_o,
    input  sdo_oe,
    output cs_n,
    output reset_n,
    output wake,
    input  intr
  );
endinterface : rffe_link_if

// ===== rtl/rffe_device.sv
// Radio front-end device: serial registers and amplifier pin control
`timescale 1ns/100ps
module rffe_device
  import rffe_pkg::*;
(
  rffe_link_if.device LINK,
  input  wire logic   RX_ACTIVE,
  input  wire logic   TX_ACTIVE,
  input  wire logic   SLEEP_REQ,
  input  wire logic   EVENT_IN,
  input  wire logic [7:0] RSSI_RAW,
  output logic        AMP_ENABLE_PIN,
  output logic        LOW_NOISE_ENABLE_PIN,
  output logic        AMP_SUPPLY_ENABLE_PIN,
  output logic        ASLEEP,
  output logic [7:0]  RSSI_VALUE
);
  logic [7:0] mode_ff;
  logic [7:0] level_ff;
  logic [7:0] dir_ff;
  logic        sleep_ff;
  logic [15:0] shift_ff;
  logic [4:0]  cnt_ff;
  logic [7:0]  rd_ff;
  logic        intr_ff;
  logic        frame_clr;
  logic        front_end;
  logic        rst;
  logic [15:0] nxt_shift;
  logic        last_bit;
  logic [5:0]  addr;
  logic [7:0]  read_val;

  // Reset pin acts as global reset; link clock runs only in frames,
  // so reset is asynchronous to the serial logic by nature
  assign rst = ~LINK.reset_n;
  assign frame_clr = rst | LINK.cs_n;
  assign nxt_shift = {shift_ff[14:0], LINK.sdi};
  assign last_bit = (cnt_ff == 5'(FRAME_BITS - 1));
  // Address sits in the low bits once eight bits are in
  assign addr = shift_ff[5:0];

  always_comb
  begin
    if (addr == REG_TEST_MODE)
      read_val = mode_ff;
    else if (addr == REG_LEVEL || addr == REG_LEVEL_ALT)
      read_val = level_ff;
    else if (addr == REG_DIRECTION)
      read_val = dir_ff;
    else
      read_val = 8'h00;
  end

  // Frame: pad, write flag, 6-bit address, 8 data bits, MSB first
  always_ff @(posedge LINK.sck or posedge rst)
  begin
    if (rst)
    begin
      shift_ff <= 16'h0000;
      mode_ff  <= RST_REG;
      level_ff <= RST_REG;
      dir_ff   <= RST_REG;
    end
    else if (!LINK.cs_n)
    begin
      shift_ff <= nxt_shift;
      // Whole frame only stands complete in nxt_shift at the last rise
      if (last_bit && nxt_shift[14])
      begin
        if (nxt_shift[13:8] == REG_TEST_MODE)
          mode_ff <= nxt_shift[7:0];
        else if (nxt_shift[13:8] == REG_LEVEL ||
                 nxt_shift[13:8] == REG_LEVEL_ALT)
          level_ff <= nxt_shift[7:0];
        else if (nxt_shift[13:8] == REG_DIRECTION)
          dir_ff <= nxt_shift[7:0];
      end
    end
  end

  // Link clock is idle while deselected, so deselect clears the
  // count at once; a cut frame leaves nothing for the next one
  always_ff @(posedge LINK.sck or posedge frame_clr)
  begin
    if (frame_clr)
      cnt_ff <= 5'h00;
    else
      cnt_ff <= cnt_ff + 5'h01;
  end

  // Read data loads after address byte, shifts on falling edge
  always_ff @(negedge LINK.sck or posedge rst)
  begin
    if (rst)
      rd_ff <= 8'h00;
    else if (cnt_ff == 5'h08)
      rd_ff <= read_val;
    else
      rd_ff <= {rd_ff[6:0], 1'b0};
  end

  assign LINK.sdo_o  = rd_ff[7];
  assign LINK.sdo_oe = ~LINK.cs_n;

  // Link clock is stopped in sleep, so the wake edge itself clears it
  always_ff @(posedge SLEEP_REQ or posedge LINK.wake or posedge rst)
  begin
    if (rst)
      sleep_ff <= 1'b0;
    else if (LINK.wake)
      sleep_ff <= 1'b0;
    else
      sleep_ff <= 1'b1;
  end
  assign ASLEEP = sleep_ff;

  always_ff @(posedge EVENT_IN or posedge rst)
  begin
    if (rst)
      intr_ff <= 1'b0;
    else
      intr_ff <= ~intr_ff;
  end
  assign LINK.intr = intr_ff;

  assign front_end = (mode_ff[2:0] == MODE_FRONT_END);

  // Front-end mode lets radio activity steer the amp and low-noise enables; supply enable stays manual
  always_comb
  begin
    if (front_end)
    begin
      AMP_ENABLE_PIN       = TX_ACTIVE;
      LOW_NOISE_ENABLE_PIN = RX_ACTIVE & ~TX_ACTIVE;
    end
    else
    begin
      // Manual levels only appear when the pin is an output
      AMP_ENABLE_PIN       = dir_ff[BIT_AMP_EN] &
                             level_ff[BIT_AMP_EN];
      LOW_NOISE_ENABLE_PIN = dir_ff[BIT_LNA_EN] &
                             level_ff[BIT_LNA_EN];
    end
  end
  assign AMP_SUPPLY_ENABLE_PIN = dir_ff[BIT_SUPPLY_EN] &
                                 level_ff[BIT_SUPPLY_EN];

  // Gain of the low-noise stage is deliberately not removed
  assign RSSI_VALUE = RSSI_RAW;
endmodule : rffe_device

// ===== tb/rffe_link_asserts.sv
// Protocol assertions on the front-end serial link
`timescale 1ns/100ps
module rffe_link_asserts
  import rffe_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_oe,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic wake
);
  logic       sck_q_ff;
  logic [4:0] rise_ff;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Counting rises catches a short or long frame
  always_ff @(posedge CORE_CLK)
    sck_q_ff <= sck;
  always_ff @(posedge CORE_CLK)
    if (SYS_RST || cs_n)
      rise_ff <= 5'h00;
    else if (sck && !sck_q_ff)
      rise_ff <= rise_ff + 5'h01;
  sequence high_phase;
    sck[*4] ##1 !sck;
  endsequence
  chk_oe_in_frame: assert property (!cs_n |-> sdo_oe)
    else $error("sdo not driven in frame");
  chk_oe_released: assert property (cs_n |-> !sdo_oe)
    else $error("sdo driven while deselected");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("sck moves outside frame");
  chk_sck_half: assert property ($rose(sck) |-> high_phase)
    else $error("sck high phase wrong");
  chk_sdi_stable: assert property ($rose(sck) |-> $stable(sdi))
    else $error("sdi changed at sck rise");
  chk_frame_bits: assert property ($rose(cs_n) |-> rise_ff == 5'h10)
    else $error("frame bit count wrong");
  chk_first_rise: assert property ($fell(cs_n) |-> ##[1:12] $rose(sck))
    else $error("frame did not start");
  chk_reset_idle: assert property
    ($fell(SYS_RST) |-> cs_n && !sck && !reset_n && !wake)
    else $error("link not idle after reset");
endmodule : rffe_link_asserts

// ===== tb/rf_front_end_switch_control_tb.sv
// Bench joining host and device ends of the front-end link
`timescale 1ns/100ps
`define CHK(g, e) check_count++; \
  if ((g) !== (e)) begin failures++; \
  $display("BAD %0t %h %h", $time, g, e); end
module rf_front_end_switch_control_tb
  import rffe_pkg::*;
;
  logic        clk, rst, wr, rd, rx, tx, slp, evt, amp, lna, sup, asl;
  logic [2:0]  addr;
  logic [15:0] wdata, rdata, rv;
  logic [7:0]  rraw, rval;
  int          failures, check_count;
  rffe_link_if link ();
  rffe_host u_rffe_host (.CORE_CLK(clk), .SYS_RST(rst), .LINK(link.host),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  rffe_device u_rffe_device (.LINK(link.device), .RX_ACTIVE(rx),
    .TX_ACTIVE(tx), .SLEEP_REQ(slp), .EVENT_IN(evt), .RSSI_RAW(rraw),
    .AMP_ENABLE_PIN(amp), .LOW_NOISE_ENABLE_PIN(lna),
    .AMP_SUPPLY_ENABLE_PIN(sup), .ASLEEP(asl), .RSSI_VALUE(rval));
  rffe_link_asserts u_rffe_link_asserts (.CORE_CLK(clk), .SYS_RST(rst),
    .sck(link.sck), .sdi(link.sdi), .sdo_oe(link.sdo_oe),
    .cs_n(link.cs_n), .reset_n(link.reset_n), .wake(link.wake));
  task automatic finish_test;
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic bus(input logic [2:0] a, input logic [15:0] d, input bit w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : bus
  // Busy may lag the launch, so give it two cycles first
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    bus(3'(HOST_STAT_ADDR), 16'h0000, 0);
    while (rv[0] !== 1'b0 && n < 200)
    begin
      bus(3'(HOST_STAT_ADDR), 16'h0000, 0);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      finish_test();
    end
  endtask : wait_idle
  task automatic dev_wr(input logic [5:0] a, input logic [7:0] d);
    bus(3'(HOST_CTRL_ADDR), {2'b01, a, d}, 1);
    wait_idle();
  endtask : dev_wr
  task automatic dev_chk(input logic [5:0] a, input logic [7:0] e);
    bus(3'(HOST_CTRL_ADDR), {2'b00, a, 8'h00}, 1);
    wait_idle();
    bus(3'(HOST_RDATA_ADDR), 16'h0000, 0);
    `CHK(rv[7:0], e)
  endtask : dev_chk
  task automatic pin_chk(input logic [1:0] e);
    @(posedge clk);
    #1;
    `CHK({lna, amp}, e)
  endtask : pin_chk
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {rst, wr, rd, rx, tx, slp, evt, addr, wdata} = {7'h40, 3'h0, 16'h0000};
    rraw = 8'h5a;
    failures = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(3'(HOST_PINS_ADDR), 16'h0000, 0);
    `CHK(rv[1:0], 2'b00)
    bus(3'(HOST_PINS_ADDR), 16'h0001, 1);
    dev_chk(REG_DIRECTION, RST_REG);
    dev_chk(6'h10, 8'h00);
    dev_wr(REG_TEST_MODE, 8'h00);
    dev_wr(REG_LEVEL, 8'h0e);
    pin_chk(2'b00);
    `CHK(sup, 1'b0)
    dev_wr(REG_DIRECTION, 8'h06);
    pin_chk(2'b11);
    dev_wr(REG_LEVEL_ALT, 8'h0c);
    pin_chk(2'b10);
    dev_chk(REG_LEVEL, 8'h0c);
    // Second launch lands while busy and must be dropped
    bus(3'(HOST_CTRL_ADDR), {2'b01, REG_LEVEL, 8'h04}, 1);
    dev_wr(REG_LEVEL, 8'h08);
    dev_chk(REG_LEVEL, 8'h04);
    dev_wr(REG_TEST_MODE, {5'h00, MODE_FRONT_END});
    @(posedge clk) tx <= 1'b1;
    pin_chk(2'b01);
    @(posedge clk) tx <= 1'b0;
    rx <= 1'b1;
    pin_chk(2'b10);
    dev_chk(REG_TEST_MODE, 8'h07);
    dev_wr(REG_TEST_MODE, 8'h00);
    dev_wr(REG_DIRECTION, 8'h0e);
    dev_wr(REG_LEVEL, 8'h08);
    pin_chk(2'b00);
    `CHK(sup, 1'b1)
    dev_wr(REG_LEVEL, 8'h00);
    `CHK(sup, 1'b0)
    @(posedge clk) slp <= 1'b1;
    dev_chk(REG_LEVEL, 8'h00);
    `CHK(asl, 1'b1)
    bus(3'(HOST_PINS_ADDR), 16'h0003, 1);
    dev_chk(REG_LEVEL, 8'h00);
    `CHK(asl, 1'b0)
    bus(3'(HOST_PINS_ADDR), 16'h0001, 1);
    dev_wr(REG_TEST_MODE, 8'h07);
    dev_chk(REG_TEST_MODE, 8'h07);
    @(posedge clk) evt <= 1'b1;
    dev_chk(REG_DIRECTION, 8'h0e);
    bus(3'(HOST_STAT_ADDR), 16'h0000, 0);
    `CHK(rv[2:0], 3'b110)
    `CHK(rval, 8'h5a)
    bus(3'(HOST_PINS_ADDR), 16'h0000, 1);
    bus(3'(HOST_PINS_ADDR), 16'h0001, 1);
    dev_chk(REG_TEST_MODE, RST_REG);
    finish_test();
  end
endmodule : rf_front_end_switch_control_tb
